/* logic/rdp_map.svh */
// Timing and field constants for the dual reduced-pin Ethernet port block
`ifndef RDP_MAP_SVH
`define RDP_MAP_SVH
`define RDP_SYS_PERIOD_NS 10
`define RDP_TXC_PERIOD_10_NS 400
`define RDP_TXC_PERIOD_100_NS 40
`define RDP_TXC_CYC_10 (`RDP_TXC_PERIOD_10_NS / `RDP_SYS_PERIOD_NS)
`define RDP_TXC_CYC_100 (`RDP_TXC_PERIOD_100_NS / `RDP_SYS_PERIOD_NS)
`define RDP_NIB_LO 3:0
`define RDP_NIB_HI 7:4
`define RDP_PORTS 2
`define RDP_SYNC_W 6
`endif

/* logic/rdp_pkg.sv */
// Types for the dual reduced-pin Ethernet port block
package rdp_pkg;
  typedef enum logic {
    RDP_SPD_10,
    RDP_SPD_100
  } rdp_speed_t;
  typedef enum logic {
    RDP_RX_WAIT_RISE,
    RDP_RX_WAIT_FALL
  } rdp_rx_state_t;
endpackage

/* logic/rdp_buf.sv */
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module rdp_buf #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  logic [W-1:0] mem_q [0:1];
  logic rd_q;
  logic wr_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule

/* logic/rdp_top.sv */
// Dual reduced-pin double-edge Ethernet port pair, 10/100 Mbit/s only
// What this block does
// - Receive data nibbles are taken on both receive clock edges, rising into bits 3-0, falling into bits 7-4.
// - The receive control line is read as data-valid at the rising edge and as error at the falling edge.
// - Transmit data carries bits 3-0 for the rising transmit clock edge and bits 7-4 for the falling edge.
// - The transmit control line carries enable for the rising edge and error for the falling edge.
// - The transmit clock is always driven out delayed so data sits centred on its edges, with no way to turn that off.
// - Port 0 runs only at 10 or 100 Mbit/s, with no gigabit mode.
// - Port 1 likewise runs only at 10 or 100 Mbit/s, with no gigabit mode.
`timescale 1ns/1ps
`include "rdp_map.svh"
module rdp_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Link rate per port, 1 selects 100 Mbit/s, 0 selects 10 Mbit/s
  input wire logic [`RDP_PORTS-1:0] speed_100_i,
  // Receive pins from the PHY
  input wire logic [`RDP_PORTS-1:0] rgmii_rxc_i,
  input wire logic [`RDP_PORTS-1:0][3:0] rgmii_rxd_i,
  input wire logic [`RDP_PORTS-1:0] rgmii_rxctl_i,
  // Transmit pins to the PHY
  output logic [`RDP_PORTS-1:0] rgmii_txc_o,
  output logic [`RDP_PORTS-1:0][3:0] rgmii_txd_o,
  output logic [`RDP_PORTS-1:0] rgmii_txctl_o,
  // Received bytes toward the switch subsystem
  output logic [`RDP_PORTS-1:0] rx_valid_o,
  input wire logic [`RDP_PORTS-1:0] rx_ready_i,
  output logic [`RDP_PORTS-1:0][7:0] rx_data_o,
  output logic [`RDP_PORTS-1:0] rx_err_o,
  output logic [`RDP_PORTS-1:0] rx_drop_o,
  // Bytes to transmit from the switch subsystem
  input wire logic [`RDP_PORTS-1:0] tx_valid_i,
  output logic [`RDP_PORTS-1:0] tx_ready_o,
  input wire logic [`RDP_PORTS-1:0][7:0] tx_data_i,
  input wire logic [`RDP_PORTS-1:0] tx_err_i
);
  localparam logic [5:0] CYC_10 = 6'(`RDP_TXC_CYC_10);
  localparam logic [5:0] CYC_100 = 6'(`RDP_TXC_CYC_100);

  genvar p;
  generate
    for (p = 0; p < `RDP_PORTS; p++) begin : g_port
      // Receive side: all pins pass two flops before use
      logic [`RDP_SYNC_W-1:0] sync1_q;
      logic [`RDP_SYNC_W-1:0] sync2_q;
      logic rxc_prev_q;
      logic rise;
      logic fall;
      rdp_pkg::rdp_rx_state_t rx_state_q;
      logic [3:0] lo_q;
      logic dv_q;
      logic push_q;
      logic [8:0] push_data_q;
      logic rxb_ready;
      logic [8:0] rxb_out;
      logic drop_q;

      always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
          sync1_q <= '0;
          sync2_q <= '0;
          rxc_prev_q <= 1'b0;
        end else begin
          sync1_q <= {rgmii_rxc_i[p], rgmii_rxctl_i[p], rgmii_rxd_i[p]};
          sync2_q <= sync1_q;
          rxc_prev_q <= sync2_q[5];
        end
      end

      // Receive clock is assumed already delayed against data by the PHY
      assign rise = sync2_q[5] & ~rxc_prev_q;
      assign fall = ~sync2_q[5] & rxc_prev_q;

      always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
          rx_state_q <= rdp_pkg::RDP_RX_WAIT_RISE;
          lo_q <= 4'h0;
          dv_q <= 1'b0;
          push_q <= 1'b0;
          push_data_q <= 9'h000;
        end else begin
          push_q <= 1'b0;
          case (rx_state_q)
            rdp_pkg::RDP_RX_WAIT_RISE: begin
              // A falling edge seen while waiting here has no partner and is skipped
              if (rise) begin
                lo_q <= sync2_q[3:0];
                dv_q <= sync2_q[4];
                rx_state_q <= rdp_pkg::RDP_RX_WAIT_FALL;
              end
            end
            rdp_pkg::RDP_RX_WAIT_FALL: begin
              if (fall) begin
                // Byte formed only from nibbles of one clock period
                push_q <= dv_q;
                push_data_q <= {sync2_q[4], sync2_q[3:0], lo_q};
                rx_state_q <= rdp_pkg::RDP_RX_WAIT_RISE;
              end
            end
            default: begin
              rx_state_q <= rdp_pkg::RDP_RX_WAIT_RISE;
            end
          endcase
        end
      end

      // A byte arriving while the buffer is full is lost and flagged
      always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
          drop_q <= 1'b0;
        end else begin
          drop_q <= push_q & ~rxb_ready;
        end
      end

      // Two entries absorb a short stall on the switch side
      rdp_buf #(
        .W(9)
      ) u_rx_buf (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(push_q),
        .in_ready_o(rxb_ready),
        .in_data_i(push_data_q),
        .out_valid_o(rx_valid_o[p]),
        .out_ready_i(rx_ready_i[p]),
        .out_data_o(rxb_out)
      );

      assign rx_data_o[p] = rxb_out[7:0];
      assign rx_err_o[p] = rxb_out[8];
      assign rx_drop_o[p] = drop_q;

      // Transmit side: clock made by division, only 10 or 100 Mbit/s rates
      rdp_pkg::rdp_speed_t speed;
      rdp_pkg::rdp_speed_t speed_q;
      logic [5:0] per;
      logic [5:0] phase_q;
      logic txb_valid;
      logic txb_pop;
      logic [8:0] txb_out;
      logic [3:0] hi_q;
      logic er_q;
      logic [3:0] txd_q;
      logic txctl_q;
      logic txc_q;

      assign speed = speed_100_i[p] ? rdp_pkg::RDP_SPD_100 : rdp_pkg::RDP_SPD_10;
      assign per = (speed_q == rdp_pkg::RDP_SPD_100) ? CYC_100 : CYC_10;
      assign txb_pop = (phase_q == 6'h00);

      // Rate is taken only at a period boundary, so a change never cuts a clock pulse
      always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
          speed_q <= speed;
        end else if (phase_q >= per - 6'h01) begin
          speed_q <= speed;
        end
      end

      // Phase counter spans one transmit clock period
      always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
          phase_q <= 6'h00;
        end else if (phase_q >= per - 6'h01) begin
          phase_q <= 6'h00;
        end else begin
          phase_q <= phase_q + 6'h01;
        end
      end

      always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
          hi_q <= 4'h0;
          er_q <= 1'b0;
          txd_q <= 4'h0;
          txctl_q <= 1'b0;
        end else if (phase_q == 6'h00) begin
          // Empty buffer at period start sends zero in both slots
          hi_q <= txb_valid ? txb_out[7:4] : 4'h0;
          er_q <= txb_valid & txb_out[8];
          txd_q <= txb_valid ? txb_out[3:0] : 4'h0;
          txctl_q <= txb_valid;
        end else if (phase_q == (per >> 1)) begin
          txd_q <= hi_q;
          txctl_q <= er_q;
        end
      end

      // Clock edges land a quarter period after each data change
      always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
          txc_q <= 1'b0;
        end else if (phase_q == (per >> 2)) begin
          txc_q <= 1'b1;
        end else if (phase_q == ((per >> 1) + (per >> 2))) begin
          txc_q <= 1'b0;
        end
      end

      // Two entries let the switch side hand over a byte while one waits
      rdp_buf #(
        .W(9)
      ) u_tx_buf (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(tx_valid_i[p]),
        .in_ready_o(tx_ready_o[p]),
        .in_data_i({tx_err_i[p], tx_data_i[p]}),
        .out_valid_o(txb_valid),
        .out_ready_i(txb_pop),
        .out_data_o(txb_out)
      );

      assign rgmii_txc_o[p] = txc_q;
      assign rgmii_txd_o[p] = txd_q;
      assign rgmii_txctl_o[p] = txctl_q;
    end
  endgenerate
endmodule

/* verif/rdp_checker.sv */
// Pin-level and receive-stream assertions for the port pair
`timescale 1ns/1ps
module rdp_checker (
  // Clock, reset and rate
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [1:0] speed_100_i,
  // Pins and receive stream
  input wire logic [1:0] rgmii_txc_o,
  input wire logic [1:0][3:0] rgmii_txd_o,
  input wire logic [1:0] rgmii_txctl_o,
  input wire logic [1:0] rx_valid_o,
  input wire logic [1:0] rx_ready_i,
  input wire logic [1:0][7:0] rx_data_o,
  input wire logic [1:0] rx_drop_o
);
  wire logic c0 = rgmii_txc_o[0];
  wire logic c1 = rgmii_txc_o[1];
  wire logic f0 = speed_100_i[0];
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  // Two cycles at one level, then the other
  sequence s_half(c);
    c [*2] ##1 !c;
  endsequence
  a_tx_half0: assert property ($rose(c0) && f0 |-> s_half(c0))
    else $error("txc0 high time");
  a_tx_low0: assert property ($fell(c0) && f0 |-> s_half(!c0))
    else $error("txc0 low time");
  a_tx_half1: assert property ($rose(c1) && speed_100_i[1] |-> s_half(c1))
    else $error("txc1 high time");
  a_data_lead: assert property (f0 && $changed(rgmii_txd_o[0]) |=> $changed(c0))
    else $error("txd0 not ahead of txc0");
  a_ctl_lead: assert property (f0 && $changed(rgmii_txctl_o[0]) |=> $changed(c0))
    else $error("txctl0 not ahead of txc0");
  a_edge_still: assert property ($changed(c1) |->
    $stable(rgmii_txd_o[1]) && $stable(rgmii_txctl_o[1])) else $error("txd1 moved at edge");
  a_rx_hold: assert property (rx_valid_o[0] && !rx_ready_i[0] |=>
    rx_valid_o[0] && $stable(rx_data_o[0])) else $error("rx byte not held");
  a_drop_full: assert property (rx_drop_o[0] |-> rx_valid_o[0] ##1 !rx_drop_o[0])
    else $error("bad drop pulse");
endmodule
bind rdp_top rdp_checker u_rdp_checker (.clk_sys_i, .rst_b_i, .speed_100_i, .rgmii_txc_o,
  .rgmii_txd_o, .rgmii_txctl_o, .rx_valid_o, .rx_ready_i, .rx_data_o, .rx_drop_o);

/* verif/rdp_phy_model.sv */
// Receive-side PHY stand-in for one port
`timescale 1ns/1ps
module rdp_phy_model (
  // Receive pins toward the block
  output logic rxc_o,
  output logic [3:0] rxd_o,
  output logic rxctl_o
);
  initial begin
    rxc_o = 1'b0;
    rxd_o = 4'hF;
    rxctl_o = 1'b1;
  end
  // Clock stands still between bytes; lines toggle once released
  task automatic send(input logic [7:0] d, input logic dv, input logic er);
    rxd_o = d[3:0];
    rxctl_o = dv;
    #10 rxc_o = 1'b1;
    #30 rxd_o = d[7:4];
    rxctl_o = er;
    #10 rxc_o = 1'b0;
    #20 rxd_o = ~rxd_o;
    rxctl_o = ~rxctl_o;
    #10;
  endtask
endmodule

/* verif/test_rdp_top.sv */
// Self-checking bench for the port pair
`timescale 1ns/1ps
module test_rdp_top;
  logic clk_sys_i;
  logic rst_b_i;
  logic [1:0] spd, rdy, vld, te, dropped;
  logic [1:0][7:0] td;
  wire logic [1:0] rxc, rxctl, txc, txctl, rv, re, rdrop, trdy;
  wire logic [1:0][3:0] rxd, txd;
  wire logic [1:0][7:0] rd;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  rdp_top u_rdp_top (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .speed_100_i(spd),
    .rgmii_rxc_i(rxc), .rgmii_rxd_i(rxd), .rgmii_rxctl_i(rxctl), .rgmii_txc_o(txc),
    .rgmii_txd_o(txd), .rgmii_txctl_o(txctl), .rx_valid_o(rv), .rx_ready_i(rdy),
    .rx_data_o(rd), .rx_err_o(re), .rx_drop_o(rdrop), .tx_valid_i(vld),
    .tx_ready_o(trdy), .tx_data_i(td), .tx_err_i(te));
  rdp_phy_model ph0 (.rxc_o(rxc[0]), .rxd_o(rxd[0]), .rxctl_o(rxctl[0]));
  rdp_phy_model ph1 (.rxc_o(rxc[1]), .rxd_o(rxd[1]), .rxctl_o(rxctl[1]));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    dropped <= rst_b_i ? (dropped | rdrop) : 2'h0;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic push(input int p, input logic [8:0] v);
    int n;
    n = 0;
    vld[p] = 1'b1;
    {te[p], td[p]} = v;
    while (!trdy[p] && n < 200) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 200) begin
      failures++;
      $display("Error at %0t: transmit buffer never ready", $time);
    end
    @(negedge clk_sys_i);
  endtask
  task automatic tx_get(input int p, input logic [8:0] exp, input int half);
    logic pv;
    logic [3:0] lo;
    int hi;
    pv = 1'b1;
    hi = 0;
    repeat (400) begin
      @(negedge clk_sys_i);
      if (!pv && txc[p] && txctl[p]) break;
      pv = txc[p];
    end
    lo = txd[p];
    while (txc[p] && hi < 99) begin
      @(negedge clk_sys_i);
      hi++;
    end
    chk({1'b1, txctl[p], txd[p], lo}, {1'b1, exp});
    chk(10'(hi), 10'(half));
  endtask
  task automatic send(input int p, input logic [7:0] d, input logic dv, input logic er);
    if (p == 0) ph0.send(d, dv, er);
    else ph1.send(d, dv, er);
  endtask
  task automatic rx_run(input int p);
    rdy[p] = 1'b0;
    send(p, 8'hA5, 1'b1, 1'b0);
    send(p, 8'h96, 1'b0, 1'b1);
    send(p, 8'h3C, 1'b1, 1'b1);
    send(p, 8'h5A, 1'b1, 1'b0);
    repeat (10) @(negedge clk_sys_i);
    chk(10'(dropped[p]), 10'h001);
    for (int i = 0; i < 2; i++) begin
      chk({rv[p], re[p], rd[p]}, i == 0 ? 10'h2A5 : 10'h33C);
      rdy[p] = 1'b1;
      @(negedge clk_sys_i);
      rdy[p] = 1'b0;
      @(negedge clk_sys_i);
    end
    chk(10'(rv[p]), 10'h000);
  endtask
  initial begin
    rst_b_i = 1'b0;
    spd = 2'h0;
    rdy = 2'h0;
    vld = 2'h0;
    td = '0;
    te = 2'h0;
    for (int s = 0; s < 2; s++) begin
      rst_b_i = 1'b0;
      spd = {2{s[0]}};
      repeat (6) @(negedge clk_sys_i);
      rst_b_i = 1'b1;
      chk({rv, rdrop, trdy, txctl, txc}, 10'h030);
      for (int p = 0; p < 2; p++) begin
        fork
          begin
            push(p, 9'h0A5);
            push(p, 9'h13C);
            push(p, 9'h05A);
            vld[p] = 1'b0;
          end
          begin
            tx_get(p, 9'h0A5, s ? 2 : 20);
            tx_get(p, 9'h13C, s ? 2 : 20);
            tx_get(p, 9'h05A, s ? 2 : 20);
          end
        join
        rx_run(p);
      end
    end
    end_sim();
  end
endmodule
